// >>> test/etm_contact_model.sv
// Contact-side model that drives the run and auxiliary inputs.
`timescale 1ns/1ps
module etm_contact_model (
	// Clock.
	input wire i_clock,
	// Requested contact levels.
	input wire i_run_req,
	input wire i_aux_req,
	// Contact outputs.
	output reg o_run = 1'b0,
	output reg o_aux = 1'b0
);
	always @(posedge i_clock) begin
		o_run <= i_run_req;
		o_aux <= i_aux_req;
	end
endmodule // etm_contact_model

// >>> test/etm_hourmeter_asserts.sv
// Concurrent checks on the ports of the hourmeter channel.
`timescale 1ns/1ps
`include "etm_consts.vh"
module etm_hourmeter_asserts (
	// Clock and reset.
	input wire i_clock,
	input wire i_rst,
	// APB slave.
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire o_pready,
	input wire o_pslverr,
	// Field side.
	input wire i_aux_input,
	input wire i_logic_chan_reset,
	input wire o_aux_state,
	input wire o_counting
);
	// Shadow of the control register, updated at the completing edge of a write.
	reg [31:0] ctl = `ETM_CTRL_RESET;
	always @(posedge i_clock) begin
		if (i_rst)
			ctl <= `ETM_CTRL_RESET;
		else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `ETM_OFS_CTRL)
			ctl <= i_pwdata;
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_wait;
		$rose(i_penable) && i_psel |-> !o_pready ##1 o_pready ##1 !o_pready;
	endproperty
	a_wait: assert property (p_wait) else $error("pready timing wrong");
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_addr;
		o_pready |-> o_pslverr == (i_paddr[1:0] != 2'h0 || i_paddr > 12'h01c);
	endproperty
	a_addr: assert property (p_addr) else $error("pslverr wrong for address");
	property p_hold;
		$changed(o_prdata) |-> o_pready;
	endproperty
	a_hold: assert property (p_hold) else $error("prdata changed outside a transfer");
	property p_sync;
		$changed(o_aux_state) |-> $past(i_aux_input, 2) == o_aux_state;
	endproperty
	a_sync: assert property (p_sync) else $error("aux state ahead of pin");
	property p_inh;
		$rose(o_aux_state) && ctl[3:2] == `ETM_TRIG_HIGH && (ctl[5:4] == `ETM_AUX_INHIBIT ||
			(ctl[5:4] == `ETM_AUX_RESET && ctl[7])) |-> ##[0:3] !o_counting;
	endproperty
	a_inh: assert property (p_inh) else $error("aux did not stop counting");
	property p_lrst;
		ctl[6] && i_logic_chan_reset |-> ##[0:2] !o_counting;
	endproperty
	a_lrst: assert property (p_lrst) else $error("logic reset did not act");
	property p_quiet;
		disable iff (1'b0) i_rst |=> !o_pready && !o_counting && !o_aux_state;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs active in reset");
	c_err: cover property (o_pslverr);
	c_cnt: cover property ($rose(o_counting));
	c_aux: cover property ($rose(o_aux_state));
endmodule // etm_hourmeter_asserts
bind etm_hourmeter etm_hourmeter_asserts u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_aux_input(i_aux_input),
	.i_logic_chan_reset(i_logic_chan_reset), .o_aux_state(o_aux_state), .o_counting(o_counting));

// >>> test/tb_top.sv
// Self-checking bench of the hourmeter channel.
`timescale 1ns/1ps
`include "etm_consts.vh"
module tb_top;
	reg i_clock = 1'b0;
	reg i_rst = 1'b1;
	reg psel = 1'b0, pen = 1'b0, pwr = 1'b0, rq = 1'b0, aq = 1'b0, lr = 1'b0, rerr;
	reg [11:0] pa = 12'h000;
	reg [31:0] pwd = 32'h00000000, rd, v;
	wire run, aux, rdy, serr, ast, blw, abv, cnt;
	wire [31:0] prd;
	integer err_count = 0, compares = 0, cycles = 0;
	etm_contact_model u_pm (.i_clock(i_clock), .i_run_req(rq), .i_aux_req(aq), .o_run(run), .o_aux(aux));
	etm_hourmeter #(.TICK_CYC(10), .CLK_HZ(1000)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd),
		.o_pready(rdy), .o_pslverr(serr), .i_run(run), .i_aux_input(aux), .i_logic_chan_reset(lr),
		.o_aux_state(ast), .o_below_limit_flag(blw), .o_above_limit_flag(abv), .o_counting(cnt));
	task check(input string n, input [31:0] s, input [31:0] e);
		begin
			compares = compares + 1;
			if (s !== e) begin
				err_count = err_count + 1;
				$display("ERROR %0s expected %h seen %h", n, e, s);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge i_clock);
			psel <= 1'b1;
			pwr <= w;
			pa <= a;
			pwd <= d;
			@(posedge i_clock);
			pen <= 1'b1;
			@(posedge i_clock);
			while (rdy !== 1'b1)
				@(posedge i_clock);
			rd = prd;
			rerr = serr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task cfg(input [1:0] r, input [1:0] a, input [1:0] f, input [1:0] s);
		apb(1, `ETM_OFS_CTRL, {23'h0, 1'b1, s, f, a, r});
	endtask
	task rcnt(input [31:0] lo, input [31:0] hi);
		begin
			apb(0, `ETM_OFS_CNTL, 0);
			v = rd;
			check("count", {31'h0, rd >= lo && rd <= hi}, 1);
		end
	endtask
	task t_regs;
		begin
			apb(0, `ETM_OFS_CTRL, 0);
			check("ctrl", rd, `ETM_CTRL_RESET);
			apb(0, 12'h020, 0);
			check("unmapped", rerr, 1);
			apb(1, 12'h006, 3);
			check("misaligned", rerr, 1);
		end
	endtask
	task t_level(input [1:0] m, input act);
		begin
			rq <= ~act;
			cfg(m, 0, 0, 0);
			apb(1, `ETM_OFS_CMD, 1);
			repeat (2) begin
				rq <= act;
				repeat (100) @(posedge i_clock);
				check("counting", cnt, 1);
				rq <= ~act;
				repeat (20) @(posedge i_clock);
				check("idle", cnt, 0);
			end
			rcnt(17, 23);
		end
	endtask
	task t_edge(input [1:0] m, input idle);
		begin
			rq <= idle;
			cfg(m, 0, 0, 0);
			repeat (20) @(posedge i_clock);
			apb(1, `ETM_OFS_CMD, 1);
			repeat (2) begin
				rq <= ~idle;
				repeat (30) @(posedge i_clock);
				rq <= idle;
				repeat (70) @(posedge i_clock);
				check("edge run", cnt, {31'h0, ~v[31]});
				v = 32'h80000000;
			end
			rcnt(8, 12);
		end
	endtask
	task t_clear;
		begin
			cfg(`ETM_TRIG_HIGH, 0, 0, `ETM_RST_DISABLE);
			lr <= 1'b1;
			repeat (20) @(posedge i_clock);
			rcnt(1, 40);
			cfg(`ETM_TRIG_HIGH, 0, 0, `ETM_RST_LOGIC);
			rcnt(0, 0);
			lr <= 1'b0;
			rq <= 1'b1;
			repeat (60) @(posedge i_clock);
			rq <= 1'b0;
			apb(1, `ETM_OFS_CMD, 1);
			rcnt(0, 0);
		end
	endtask
	task t_aux(input [1:0] f, input [1:0] s, input stop);
		begin
			cfg(`ETM_TRIG_HIGH, `ETM_TRIG_HIGH, f, s);
			rq <= 1'b1;
			repeat (50) @(posedge i_clock);
			aq <= 1'b1;
			repeat (20) @(posedge i_clock);
			check("aux stop", cnt, {31'h0, ~stop});
			check("aux state", ast, 1);
			rcnt(f == `ETM_AUX_RESET ? 0 : 3, f == `ETM_AUX_RESET ? 0 : 8);
			aq <= 1'b0;
			rq <= 1'b0;
			repeat (20) @(posedge i_clock);
		end
	endtask
	task t_limit;
		begin
			apb(1, `ETM_OFS_LOW, 5);
			apb(1, `ETM_OFS_HIGH, 10);
			apb(1, `ETM_OFS_CMD, 1);
			repeat (3) @(posedge i_clock);
			check("below", {blw, abv}, 2'h2);
			rq <= 1'b1;
			repeat (200) @(posedge i_clock);
			check("above", {blw, abv}, 2'h1);
			rq <= 1'b0;
			apb(0, `ETM_OFS_CNTH, 0);
			check("count high", rd, 0);
		end
	endtask
	task t_filt;
		begin
			apb(1, `ETM_OFS_FILT, `ETM_FILT_MAX_HZ);
			aq <= 1'b1;
			repeat (3) @(posedge i_clock);
			aq <= 1'b0;
			repeat (20) @(posedge i_clock);
			check("bounce", ast, 0);
			aq <= 1'b1;
			repeat (20) @(posedge i_clock);
			check("filtered", ast, 1);
			apb(0, `ETM_OFS_STAT, 0);
			check("stat aux", {31'h0, rd[0]}, 1);
			aq <= 1'b0;
			apb(1, `ETM_OFS_FILT, 0);
		end
	endtask
	task results;
		begin
			$display("Comparisons %0d, mismatches %0d", compares, err_count);
			if (err_count == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		forever #20 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			results;
		end
	end
	initial begin
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		t_regs;
		t_level(`ETM_TRIG_HIGH, 1'b1);
		t_level(`ETM_TRIG_LOW, 1'b0);
		v = 0;
		t_edge(`ETM_TRIG_RISE, 1'b0);
		v = 0;
		t_edge(`ETM_TRIG_FALL, 1'b1);
		t_clear;
		t_aux(`ETM_AUX_INHIBIT, `ETM_RST_DISABLE, 1'b1);
		t_aux(`ETM_AUX_RESET, `ETM_RST_EXT, 1'b1);
		t_aux(`ETM_AUX_BINARY, `ETM_RST_BOTH, 1'b0);
		t_limit;
		t_filt;
		results;
	end
endmodule // tb_top

// >>> verilog/etm_consts.vh
// Constants and register map of the elapsed-time hourmeter channel.
// Function
// - Measure time between run start and stop, optionally summing successive periods.
// - High-level run trigger: count only while run input is high.
// - Low-level run trigger: count only while run input is low.
// - Rising-edge run trigger: one rising edge starts, the next stops.
// - Falling-edge run trigger: one falling edge starts, the next stops.
// - Manual reset command clears the accumulated time at once.
// - Logic-channel reset mode clears on a high channel; disable adds no reset.
// - Chosen reset logic channel clears the counter when its value exceeds zero.
// - External reset mode uses the aux input, only when aux function is reset.
// - Both mode: logic channel and aux input each clear; aux needs reset function.
// - Binary-input aux function leaves counting alone but aux stays readable.
// - Sampled aux state is readable whatever the aux function is.
// - Aux reset function clears at once, only with external or both reset mode.
// - Aux inhibit function suspends accumulation; the summed value is kept, a single-period reading restarts at zero.
// - High-level aux trigger holds reset or inhibit while aux is high.
// - Low-level aux trigger holds reset or inhibit while aux is low.
// - Rising aux edge resets, or inhibits until the next valid run trigger; only a run edge in edge run modes, or a change of aux function, ends the inhibit.
// - Falling aux edge resets, or inhibits until the next valid run trigger; only a run edge in edge run modes, or a change of aux function, ends the inhibit.
// - Input filter off or 10 to 90 Hz; pulses under half a period are dropped.
// - Value is in seconds with one millisecond resolution.
// - Flag below-limit under the low limit and above-limit over the high limit.
`ifndef ETM_CONSTS_VH
`define ETM_CONSTS_VH
`define ETM_CLK_HZ 25000000
`define ETM_TICK_MS 1
`define ETM_TICK_CYC (`ETM_CLK_HZ / 1000 * `ETM_TICK_MS)
// Register byte offsets.
`define ETM_OFS_CTRL 12'h000
`define ETM_OFS_FILT 12'h004
`define ETM_OFS_LOW 12'h008
`define ETM_OFS_HIGH 12'h00c
`define ETM_OFS_CMD 12'h010
`define ETM_OFS_STAT 12'h014
`define ETM_OFS_CNTL 12'h018
`define ETM_OFS_CNTH 12'h01c
// Control field positions.
`define ETM_CTRL_RUNTRIG_LSB 0
`define ETM_CTRL_AUXTRIG_LSB 2
`define ETM_CTRL_AUXFN_LSB 4
`define ETM_CTRL_RSTSEL_LSB 6
`define ETM_CTRL_SUM_BIT 8
`define ETM_CTRL_RESET 32'h00000100
`define ETM_FILT_RESET 32'h00000000
`define ETM_LIMIT_RESET 32'h00000000
// Trigger encodings.
`define ETM_TRIG_HIGH 2'h0
`define ETM_TRIG_LOW 2'h1
`define ETM_TRIG_RISE 2'h2
`define ETM_TRIG_FALL 2'h3
// Aux function encodings.
`define ETM_AUX_BINARY 2'h0
`define ETM_AUX_RESET 2'h1
`define ETM_AUX_INHIBIT 2'h2
// Reset selection encodings.
`define ETM_RST_DISABLE 2'h0
`define ETM_RST_LOGIC 2'h1
`define ETM_RST_EXT 2'h2
`define ETM_RST_BOTH 2'h3
// Filter frequency range in Hz.
`define ETM_FILT_MIN_HZ 10
`define ETM_FILT_MAX_HZ 90
`endif

// >>> verilog/etm_hourmeter.v
// Elapsed-time hourmeter channel with APB register access.
`timescale 1ns/1ps
`include "etm_consts.vh"
module etm_hourmeter #(
	parameter CNT_W = 48,
	parameter TICK_CYC = `ETM_TICK_CYC,
	parameter CLK_HZ = `ETM_CLK_HZ
) (
	// Clock and reset.
	input wire i_clock,
	input wire i_rst,
	// APB slave.
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [3:0] i_pstrb,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Field inputs.
	input wire i_run,
	input wire i_aux_input,
	input wire i_logic_chan_reset,
	// Status outputs.
	output reg o_aux_state,
	output reg o_below_limit_flag,
	output reg o_above_limit_flag,
	output reg o_counting
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Merges a write into a word under the byte strobes.
	function [31:0] strb_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] st;
		integer k;
		begin
			strb_merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (st[k]) begin
					strb_merge[k*8 +: 8] = wd[k*8 +: 8];
				end
			end
		end
	endfunction

	// Says whether a trigger setting sees its condition on a synced signal.
	function trig_hit;
		input [1:0] mode;
		input cur;
		input prev;
		begin
			case (mode)
				`ETM_TRIG_HIGH: trig_hit = cur;
				`ETM_TRIG_LOW: trig_hit = ~cur;
				`ETM_TRIG_RISE: trig_hit = cur & ~prev;
				default: trig_hit = ~cur & prev;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [31:0] ctrl;
	reg [31:0] filt;
	reg [31:0] low_limit;
	reg [31:0] high_limit;
	reg [CNT_W-1:0] count;
	reg [CNT_W-1:0] period_start;
	reg [31:0] cnt_high_latch;
	reg [1:0] sync_a;
	reg [1:0] sync_b;
	reg [1:0] filt_q;
	reg [1:0] filt_prev;
	reg [31:0] filt_cnt [0:1];
	reg [31:0] tick_cnt;
	reg tick;
	reg edge_run;
	reg edge_inhibit;
	reg manual_clear;
	wire [1:0] run_trig = ctrl[`ETM_CTRL_RUNTRIG_LSB +: 2];
	wire [1:0] aux_trig = ctrl[`ETM_CTRL_AUXTRIG_LSB +: 2];
	wire [1:0] aux_fn = ctrl[`ETM_CTRL_AUXFN_LSB +: 2];
	wire [1:0] rst_sel = ctrl[`ETM_CTRL_RSTSEL_LSB +: 2];
	wire sum_mode = ctrl[`ETM_CTRL_SUM_BIT];
	wire [1:0] raw_in = {i_aux_input, i_run};
	wire [31:0] filt_hz = {24'h000000, filt[7:0]};
	wire filt_on = (filt_hz >= `ETM_FILT_MIN_HZ) && (filt_hz <= `ETM_FILT_MAX_HZ);
	// Half a period of the chosen frequency, in clock cycles.
	wire [31:0] filt_lim = filt_on ? (CLK_HZ / 2) / filt_hz : 32'h00000000;
	wire run_s = filt_q[0];
	wire aux_s = filt_q[1];
	wire run_hit = trig_hit(run_trig, run_s, filt_prev[0]);
	wire aux_hit = trig_hit(aux_trig, aux_s, filt_prev[1]);
	wire aux_lvl = (aux_trig == `ETM_TRIG_HIGH) || (aux_trig == `ETM_TRIG_LOW);
	wire aux_rst_ok = (rst_sel == `ETM_RST_EXT) || (rst_sel == `ETM_RST_BOTH);
	wire lc_rst_ok = (rst_sel == `ETM_RST_LOGIC) || (rst_sel == `ETM_RST_BOTH);
	wire aux_clear = aux_hit && (aux_fn == `ETM_AUX_RESET) && aux_rst_ok;
	wire lc_clear = lc_rst_ok && i_logic_chan_reset;
	wire inhibit_now = (aux_fn == `ETM_AUX_INHIBIT) && ((aux_lvl && aux_hit) || edge_inhibit);
	wire run_active = (run_trig == `ETM_TRIG_HIGH || run_trig == `ETM_TRIG_LOW) ? run_hit : edge_run;
	wire clear_all = manual_clear || lc_clear || aux_clear;
	wire apb_acc = i_psel && i_penable && o_pready;
	wire apb_wr = apb_acc && i_pwrite;
	// Read data is loaded at the first access edge so that it stands while pready is high.
	wire apb_rd = i_psel && i_penable && ~o_pready && ~i_pwrite;
	wire [CNT_W-1:0] shown = sum_mode ? count : count - period_start;

	// ----------------------------------------
	// Input synchronisers and filters
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_in
			always @(posedge i_clock) begin
				if (i_rst) begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
					filt_q[g] <= 1'b0;
					filt_prev[g] <= 1'b0;
					filt_cnt[g] <= 32'h00000000;
				end else begin
					sync_a[g] <= raw_in[g];
					sync_b[g] <= sync_a[g];
					filt_prev[g] <= filt_q[g];
					// A change must stand for half a period before it is taken.
					if (sync_b[g] == filt_q[g]) begin
						filt_cnt[g] <= 32'h00000000;
					end else if (filt_cnt[g] >= filt_lim) begin
						filt_q[g] <= sync_b[g];
						filt_cnt[g] <= 32'h00000000;
					end else begin
						filt_cnt[g] <= filt_cnt[g] + 32'h00000001;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (i_rst) begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (tick_cnt == TICK_CYC - 1) begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// Run state and accumulation
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (i_rst) begin
			edge_run <= 1'b0;
			edge_inhibit <= 1'b0;
			count <= {CNT_W{1'b0}};
			period_start <= {CNT_W{1'b0}};
		end else begin
			// Each valid edge toggles timing and ends an edge inhibit.
			if (run_hit && (run_trig == `ETM_TRIG_RISE || run_trig == `ETM_TRIG_FALL)) begin
				edge_run <= ~edge_run;
				edge_inhibit <= 1'b0;
			end else if (aux_hit && ~aux_lvl && aux_fn == `ETM_AUX_INHIBIT) begin
				edge_inhibit <= 1'b1;
			end
			if (aux_fn != `ETM_AUX_INHIBIT) begin
				edge_inhibit <= 1'b0;
			end
			// Period start is captured when timing begins, for single-period reading.
			if (run_active && ~o_counting) begin
				period_start <= count;
			end
			if (clear_all) begin
				count <= {CNT_W{1'b0}};
				period_start <= {CNT_W{1'b0}};
			end else if (tick && run_active && ~inhibit_now) begin
				count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ----------------------------------------
	// APB register file
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (i_rst) begin
			ctrl <= `ETM_CTRL_RESET;
			filt <= `ETM_FILT_RESET;
			low_limit <= `ETM_LIMIT_RESET;
			high_limit <= `ETM_LIMIT_RESET;
			manual_clear <= 1'b0;
			cnt_high_latch <= 32'h00000000;
			o_prdata <= 32'h00000000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			manual_clear <= 1'b0;
			o_pready <= i_psel && i_penable && ~o_pready;
			o_pslverr <= 1'b0;
			if (i_psel && i_penable && ~o_pready) begin
				o_pslverr <= (i_paddr[1:0] != 2'h0) || (i_paddr > `ETM_OFS_CNTH);
			end
			if (apb_wr) begin
				case (i_paddr)
					`ETM_OFS_CTRL: ctrl <= strb_merge(ctrl, i_pwdata, i_pstrb) & 32'h000001ff;
					`ETM_OFS_FILT: filt <= strb_merge(filt, i_pwdata, i_pstrb) & 32'h000000ff;
					`ETM_OFS_LOW: low_limit <= strb_merge(low_limit, i_pwdata, i_pstrb);
					`ETM_OFS_HIGH: high_limit <= strb_merge(high_limit, i_pwdata, i_pstrb);
					`ETM_OFS_CMD: manual_clear <= i_pstrb[0] & i_pwdata[0];
					default: ;
				endcase
			end
			if (apb_rd) begin
				case (i_paddr)
					`ETM_OFS_CTRL: o_prdata <= ctrl;
					`ETM_OFS_FILT: o_prdata <= filt;
					`ETM_OFS_LOW: o_prdata <= low_limit;
					`ETM_OFS_HIGH: o_prdata <= high_limit;
					`ETM_OFS_STAT: o_prdata <= {28'h0000000, o_counting, o_above_limit_flag,
						o_below_limit_flag, o_aux_state};
					`ETM_OFS_CNTL: begin
						o_prdata <= shown[31:0];
						cnt_high_latch <= {{(64-CNT_W){1'b0}}, shown[CNT_W-1:32]};
					end
					`ETM_OFS_CNTH: o_prdata <= cnt_high_latch;
					default: o_prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_aux_state <= 1'b0;
			o_below_limit_flag <= 1'b0;
			o_above_limit_flag <= 1'b0;
			o_counting <= 1'b0;
		end else begin
			o_aux_state <= aux_s;
			o_below_limit_flag <= shown < {{(CNT_W-32){1'b0}}, low_limit};
			o_above_limit_flag <= shown > {{(CNT_W-32){1'b0}}, high_limit};
			o_counting <= run_active && ~inhibit_now && ~clear_all;
		end
	end

endmodule // etm_hourmeter
